// File: hw/mcq_pkg.sv
// Shared constants for the monitor channel S/Q handler.
// Assumes one frame sync pulse per host frame at the frame rate below.
package mcq_pkg;

  // ==========================================================
  // Message layout
  localparam int BYTE_W = 8;             // Monitor byte width
  localparam int NIB_W = 4;              // S1, S2 and Q channel width
  localparam int CAT_MSB = 7;            // Category nibble, upper bits
  localparam int CAT_LSB = 4;
  localparam logic [3:0] CAT_S1Q = 4'h1; // S1 or Q message category
  localparam logic [3:0] CAT_S2 = 4'h2;  // S2 message category

  // ==========================================================
  // Timing
  localparam int CHECK_MS = 5;           // Lock-up check interval, ms
  localparam int FRAME_HZ = 8000;        // Host frame rate, Hz
  localparam int CHECK_FRAMES = CHECK_MS * FRAME_HZ / 1000;
  localparam int FCNT_W = 6;             // Wide enough for CHECK_FRAMES

  // ==========================================================
  // Reset and idle values
  localparam logic HS_IDLE = 1'b1;       // Handshake bits idle high
  localparam logic [3:0] NIB_RST = 4'h0; // Holding register reset
  localparam logic [7:0] BYTE_RST = 8'hFF; // Idle monitor byte
  localparam int FIFO_DEPTH = 8;         // Outgoing message buffer

  // ==========================================================
  // Link state machines
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,  // Nothing to send
    TX_SEND = 2'b01,  // Byte out, flag low, awaiting ack
    TX_EOM = 2'b10,   // End mark out, awaiting ack release
    TX_TOEOM = 2'b11  // Timeout end mark, message is resent
  } mcq_tx_t;

  typedef enum logic {
    RX_IDLE = 1'b0,   // Watching incoming flag
    RX_ACK = 1'b1     // Byte taken, ack driven low
  } mcq_rx_t;

endpackage

// File: hw/mcq_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module mcq_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  // ==========================================================
  // Storage and pointers
  logic [W-1:0] mem_r [D];     // Flip-flop storage
  logic [AW-1:0] wr_ptr_r;     // Next slot to write
  logic [AW-1:0] rd_ptr_r;     // Next slot to read
  logic [CW-1:0] cnt_r;        // Words held

  wire do_push = in_valid & in_ready;
  wire do_pop = out_valid & out_ready;

  // Full and empty straight from the count
  assign in_ready = (cnt_r != CW'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_ptr_r];

  // Pointer wrap, depth need not be a power of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  // Write port
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= bump(wr_ptr_r);
      end
      if (do_pop) begin
        rd_ptr_r <= bump(rd_ptr_r);
      end
      cnt_r <= cnt_r + CW'(do_push) - CW'(do_pop);
    end
  end

endmodule

// File: hw/mcq_sq_handler.sv
// Monitor channel handler for one-byte S1/S2/Q maintenance messages.
// Assumes link pins are sampled on every rising link_clk edge, line side
// multiframe strobes arrive on ref_clk from same-domain logic.
`timescale 1ns/10ps
module mcq_sq_handler #(
  parameter int FIFO_D = mcq_pkg::FIFO_DEPTH
) (
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Configuration levels
  input wire logic lt_mode,
  input wire logic multiframe_disable_bit,
  input wire logic timeout_disable_bit,
  // Line side multiframe
  input wire logic mf_strobe,
  input wire logic [3:0] line_rx_s1,
  input wire logic [3:0] line_rx_s2,
  input wire logic [3:0] line_rx_q,
  output logic [3:0] line_tx_s1,
  output logic [3:0] line_tx_s2,
  output logic [3:0] line_tx_q,
  // Host frame bus, link clock domain
  input wire logic link_clk,
  input wire logic frame_sync,
  input wire logic [7:0] in_line_byte,
  input wire logic in_line_tx_flag_n,
  input wire logic in_line_read_ack_n,
  output logic [7:0] out_line_byte,
  output logic out_line_tx_flag_n,
  output logic out_line_read_ack_n
);

  // ==========================================================
  // Shared helpers
  function automatic logic [7:0] mk_msg(input logic [3:0] cat, input logic [3:0] nib);
    mk_msg = {cat, nib};
  endfunction

  // ==========================================================
  // Core domain: line side holding registers
  logic [3:0] s1_r, s2_r, q_r;           // Nibbles for the line inserter
  logic [7:0] snap_a_r, snap_b_r;        // Queued message bytes
  logic pend_a_r, pend_b_r;              // Queued message flags
  logic xbusy_r;                         // Byte handed to link, no ack yet
  logic [7:0] xbyte_r;                   // Byte held stable for the link
  logic req_tgl_r;                       // Event toggle toward link
  logic ack_s1_r, ack_s2_r, ack_d_r;     // Ack toggle synchroniser
  logic rxt_s1_r, rxt_s2_r, rxt_d_r;     // Receive toggle synchroniser
  logic [7:0] rx_byte_r;                 // Link side, stable after toggle
  logic ack_tgl_r, rx_tgl_r;             // Link event toggles toward core

  wire mf_on = ~multiframe_disable_bit;
  wire rx_evt = rxt_s2_r ^ rxt_d_r;      // New host message
  wire ack_evt = ack_s2_r ^ ack_d_r;     // Link finished a byte
  wire [3:0] rx_cat = rx_byte_r[mcq_pkg::CAT_MSB:mcq_pkg::CAT_LSB];
  wire [3:0] rx_nib = rx_byte_r[mcq_pkg::NIB_W-1:0];
  wire rx_s1q = rx_evt & mf_on & (rx_cat == mcq_pkg::CAT_S1Q);
  wire rx_s2 = rx_evt & mf_on & (rx_cat == mcq_pkg::CAT_S2);
  wire mf_take = mf_strobe & mf_on;

  // Fill side of the buffer: first message before second
  wire push_ready;
  wire push_a = pend_a_r & push_ready;
  wire push_b = pend_b_r & ~pend_a_r & push_ready;
  wire push_valid = pend_a_r | pend_b_r;
  wire [7:0] push_data = pend_a_r ? snap_a_r : snap_b_r;
  wire pop_valid;
  wire [7:0] pop_data;
  wire pop_ready = ~xbusy_r;
  wire pop_take = pop_valid & pop_ready;

  assign line_tx_s1 = s1_r;
  assign line_tx_s2 = s2_r;
  assign line_tx_q = q_r;

  // Outgoing messages wait here; a full buffer stalls the generator
  mcq_fifo #(
    .W(mcq_pkg::BYTE_W),
    .D(FIFO_D)
  ) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // Host messages land in holding registers by direction
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_r <= mcq_pkg::NIB_RST;
      s2_r <= mcq_pkg::NIB_RST;
      q_r <= mcq_pkg::NIB_RST;
    end else if (lt_mode) begin
      // Network end: host supplies S1 and S2 downstream
      if (rx_s1q) s1_r <= rx_nib;
      if (rx_s2) s2_r <= rx_nib;
    end else if (rx_s1q) begin
      // Terminal end: host supplies Q upstream, S2 ignored
      q_r <= rx_nib;
    end
  end

  // Multiframe snapshot queues report messages for the host
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      snap_a_r <= mcq_pkg::BYTE_RST;
      snap_b_r <= mcq_pkg::BYTE_RST;
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
    end else if (mf_take) begin
      // New multiframe wins over a push in the same cycle
      if (lt_mode) begin
        snap_a_r <= mk_msg(mcq_pkg::CAT_S1Q, line_rx_q);
        pend_a_r <= 1'b1;
      end else begin
        snap_a_r <= mk_msg(mcq_pkg::CAT_S1Q, line_rx_s1);
        snap_b_r <= mk_msg(mcq_pkg::CAT_S2, line_rx_s2);
        pend_a_r <= 1'b1;
        pend_b_r <= 1'b1;
      end
    end else begin
      if (push_a) pend_a_r <= 1'b0;
      if (push_b) pend_b_r <= 1'b0;
    end
  end

  // One byte at a time toward the link, held until acknowledged
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      xbusy_r <= 1'b0;
      xbyte_r <= mcq_pkg::BYTE_RST;
      req_tgl_r <= 1'b0;
    end else if (pop_take) begin
      xbusy_r <= 1'b1;
      xbyte_r <= pop_data;
      req_tgl_r <= ~req_tgl_r;
    end else if (ack_evt) begin
      xbusy_r <= 1'b0;
    end
  end

  // Toggles from the link; first stage only feeds the second
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {ack_s1_r, ack_s2_r, ack_d_r} <= 3'h0;
      {rxt_s1_r, rxt_s2_r, rxt_d_r} <= 3'h0;
    end else begin
      {ack_s1_r, ack_s2_r, ack_d_r} <= {ack_tgl_r, ack_s1_r, ack_s2_r};
      {rxt_s1_r, rxt_s2_r, rxt_d_r} <= {rx_tgl_r, rxt_s1_r, rxt_s2_r};
    end
  end

  // ==========================================================
  // Link domain: input sampling
  logic lrst_s1_r, lrst_n_r;             // Reset brought into link domain
  logic fs_s1_r, fs_s2_r, fs_d_r;        // Frame sync, two stages and edge
  logic [7:0] ib_s1_r, ib_s2_r;          // Incoming monitor byte
  logic mx_s1_r, mx_s2_r;                // Incoming transmit flag
  logic mr_s1_r, mr_s2_r;                // Incoming read ack
  logic tod_s1_r, tod_s2_r;              // Timeout disable level
  logic req_s1_r, req_s2_r, req_d_r;     // Request toggle from core

  // Reset is released on the link clock, tied to constants only
  always_ff @(posedge link_clk) begin
    lrst_s1_r <= rst_n;
    lrst_n_r <= lrst_s1_r;
  end

  // Two flops before any logic reads a pin
  always_ff @(posedge link_clk) begin
    {fs_s1_r, fs_s2_r, fs_d_r} <= {frame_sync, fs_s1_r, fs_s2_r};
    {ib_s1_r, ib_s2_r} <= {in_line_byte, ib_s1_r};
    {mx_s1_r, mx_s2_r} <= {in_line_tx_flag_n, mx_s1_r};
    {mr_s1_r, mr_s2_r} <= {in_line_read_ack_n, mr_s1_r};
    {tod_s1_r, tod_s2_r} <= {timeout_disable_bit, tod_s1_r};
    {req_s1_r, req_s2_r, req_d_r} <= {req_tgl_r, req_s1_r, req_s2_r};
  end

  // ==========================================================
  // Link domain: handshake engines
  // The outgoing engine steps once per host frame, the incoming one frees its ack on any link clock; the wait for a confirmation
  // is measured in whole frames, so the check interval tracks the frame rate.
  localparam int FW = mcq_pkg::FCNT_W;
  localparam logic [FW-1:0] LOCK_AT = FW'(mcq_pkg::CHECK_FRAMES - 1);

  mcq_pkg::mcq_tx_t tx_st_r, tx_st_nxt;  // Outgoing engine state
  mcq_pkg::mcq_rx_t rx_st_r, rx_st_nxt;  // Incoming engine state
  logic tx_pend_r;                       // A byte waits to go out
  logic [FW-1:0] fcnt_r;                 // Frames without progress

  // Frame edge and handshake levels, all from second stages
  wire frame_tick = fs_s2_r & ~fs_d_r;   // One per host frame
  wire req_evt = req_s2_r ^ req_d_r;     // Core handed a byte over
  wire in_flag = ~mx_s2_r;               // Controller offers a byte
  wire in_ack = ~mr_s2_r;                // Controller confirmed ours
  wire rx_idle = (rx_st_r == mcq_pkg::RX_IDLE);
  // Never start while an incoming message is still open
  wire tx_go = frame_tick & tx_pend_r & rx_idle & mx_s2_r;
  wire lock_up = frame_tick & (fcnt_r == LOCK_AT);
  wire tmo_fire = lock_up & ~tod_s2_r;
  wire send_hold = (tx_st_r == mcq_pkg::TX_SEND) & (tx_st_nxt == mcq_pkg::TX_SEND);
  wire tx_done = (tx_st_r == mcq_pkg::TX_EOM) & (tx_st_nxt == mcq_pkg::TX_IDLE);
  // A new request wins over a completion in the same cycle
  wire tx_pend_nxt = req_evt | (tx_pend_r & ~tx_done);
  // Counter restarts on every entry to the send state
  wire [FW-1:0] fcnt_nxt = send_hold ? fcnt_r + FW'(frame_tick) : '0;
  wire tx_low = (tx_st_nxt == mcq_pkg::TX_SEND);
  wire [7:0] tx_byte_nxt = tx_low ? xbyte_r : mcq_pkg::BYTE_RST;
  wire rx_take = frame_tick & in_flag & rx_idle;
  wire rx_ack_on = (rx_st_nxt == mcq_pkg::RX_ACK);

  // Outgoing engine: offer, wait for ack, end mark, wait for release
  always_comb begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      mcq_pkg::TX_IDLE: begin
        if (tx_go) begin
          tx_st_nxt = mcq_pkg::TX_SEND;
        end
      end
      mcq_pkg::TX_SEND: begin
        if (frame_tick && in_ack) begin
          tx_st_nxt = mcq_pkg::TX_EOM;
        end else if (tmo_fire) begin
          tx_st_nxt = mcq_pkg::TX_TOEOM;
        end
      end
      mcq_pkg::TX_EOM: begin
        if (frame_tick && !in_ack) begin
          tx_st_nxt = mcq_pkg::TX_IDLE;
        end
      end
      mcq_pkg::TX_TOEOM: begin
        // Pending stays set, so the same byte goes out again
        if (frame_tick) begin
          tx_st_nxt = mcq_pkg::TX_IDLE;
        end
      end
      default: tx_st_nxt = mcq_pkg::TX_IDLE;
    endcase
  end

  // Outgoing engine registers
  always_ff @(posedge link_clk) begin
    if (!lrst_n_r) begin
      tx_st_r <= mcq_pkg::TX_IDLE;
      tx_pend_r <= 1'b0;
      ack_tgl_r <= 1'b0;
      fcnt_r <= '0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_pend_r <= tx_pend_nxt;
      ack_tgl_r <= ack_tgl_r ^ tx_done;
      fcnt_r <= fcnt_nxt;
    end
  end

  // Incoming engine: take on flag low, hold ack until end mark
  always_comb begin
    rx_st_nxt = rx_st_r;
    case (rx_st_r)
      mcq_pkg::RX_IDLE: begin
        if (rx_take) begin
          rx_st_nxt = mcq_pkg::RX_ACK;
        end
      end
      mcq_pkg::RX_ACK: begin
        if (mx_s2_r) begin
          rx_st_nxt = mcq_pkg::RX_IDLE; // End mark frees our ack
        end
      end
      default: rx_st_nxt = mcq_pkg::RX_IDLE;
    endcase
  end

  // Incoming engine registers; byte settles before its toggle is seen
  always_ff @(posedge link_clk) begin
    if (!lrst_n_r) begin
      rx_st_r <= mcq_pkg::RX_IDLE;
      rx_tgl_r <= 1'b0;
      rx_byte_r <= mcq_pkg::BYTE_RST;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_tgl_r <= rx_tgl_r ^ rx_take;
      if (rx_take) begin
        rx_byte_r <= ib_s2_r;
      end
    end
  end

  // Link pins straight from flops, idle high
  always_ff @(posedge link_clk) begin
    if (!lrst_n_r) begin
      out_line_tx_flag_n <= mcq_pkg::HS_IDLE;
      out_line_read_ack_n <= mcq_pkg::HS_IDLE;
      out_line_byte <= mcq_pkg::BYTE_RST;
    end else begin
      out_line_tx_flag_n <= ~tx_low;
      out_line_read_ack_n <= ~rx_ack_on;
      out_line_byte <= tx_byte_nxt;
    end
  end
endmodule

// File: tb/mcq_checker.sv
// Link pin checker for the S/Q monitor handler.
// Assumes binding into mcq_sq_handler, link pins on link_clk.
`timescale 1ns/10ps
module mcq_checker (
  // Clock and reset
  input wire logic link_clk,
  input wire logic rst_n,
  // Levels and frame
  input wire logic frame_sync,
  input wire logic lt_mode,
  input wire logic multiframe_disable_bit,
  input wire logic timeout_disable_bit,
  // Link pins
  input wire logic in_line_tx_flag_n,
  input wire logic in_line_read_ack_n,
  input wire logic [7:0] out_line_byte,
  input wire logic out_line_tx_flag_n,
  input wire logic out_line_read_ack_n
);
  logic [7:0] wait_r; // Frames spent waiting on an ack
  // ==========================================
  // Wait counter, cleared by progress
  always_ff @(posedge link_clk) begin
    if (!rst_n || out_line_tx_flag_n || !in_line_read_ack_n) wait_r <= 8'h00;
    else if (frame_sync) wait_r <= wait_r + 8'h01;
  end
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Assertions
  property p_ack_cause;
    $fell(out_line_read_ack_n) |-> !$past(in_line_tx_flag_n) || !$past(in_line_tx_flag_n, 2);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without flag");
  property p_ack_free;
    in_line_tx_flag_n [*6] |-> out_line_read_ack_n;
  endproperty
  a_ack_free: assert property (p_ack_free) else $error("ack held at idle");
  property p_hold;
    !out_line_tx_flag_n && $past(!out_line_tx_flag_n) |-> $stable(out_line_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("byte moved");
  property p_cat;
    $fell(out_line_tx_flag_n) |->
      out_line_byte[7:4] == mcq_pkg::CAT_S1Q || out_line_byte[7:4] == mcq_pkg::CAT_S2;
  endproperty
  a_cat: assert property (p_cat) else $error("bad category");
  property p_dir;
    $fell(out_line_tx_flag_n) && lt_mode |-> out_line_byte[7:4] == mcq_pkg::CAT_S1Q;
  endproperty
  a_dir: assert property (p_dir) else $error("bad upstream");
  property p_mfd;
    multiframe_disable_bit [*8] |-> !$fell(out_line_tx_flag_n);
  endproperty
  a_mfd: assert property (p_mfd) else $error("sent while disabled");
  property p_tmo;
    !timeout_disable_bit |-> wait_r < 8'h54;
  endproperty
  a_tmo: assert property (p_tmo) else $error("no timeout");
  property p_tod;
    $rose(out_line_tx_flag_n) && timeout_disable_bit |->
      !$past(in_line_read_ack_n) || !$past(in_line_read_ack_n, 2);
  endproperty
  a_tod: assert property (p_tod) else $error("timeout while disabled");
  c_wait: cover property (wait_r == 8'h28);
  c_lt: cover property ($fell(out_line_tx_flag_n) && lt_mode);
  c_ack: cover property ($fell(out_line_read_ack_n));
endmodule
bind mcq_sq_handler mcq_checker mcq_checker_i (.link_clk, .rst_n, .frame_sync, .lt_mode,
  .multiframe_disable_bit, .timeout_disable_bit, .in_line_tx_flag_n, .in_line_read_ack_n,
  .out_line_byte, .out_line_tx_flag_n, .out_line_read_ack_n);

// File: tb/mcq_ctrl_model.sv
// Controller model on the host frame bus.
// Assumes one frame per two link clocks, lines pulled up when released.
`timescale 1ns/10ps
module mcq_ctrl_model (
  // Link clock
  input wire logic link_clk,
  // Pins toward the handler
  output logic frame_sync,
  output logic [7:0] in_line_byte,
  output logic in_line_tx_flag_n,
  output logic in_line_read_ack_n,
  // Pins from the handler
  input wire logic [7:0] out_line_byte,
  input wire logic out_line_tx_flag_n,
  input wire logic out_line_read_ack_n,
  // Stall control
  input wire logic ack_off
);
  logic [7:0] rxq[$]; // New offers seen
  logic seen_hi = 1'b1; // Flag level last frame
  initial begin
    frame_sync = 1'b0;
    in_line_byte = 8'hFF;
    in_line_tx_flag_n = 1'b1;
    in_line_read_ack_n = 1'b1;
  end
  always @(posedge link_clk) frame_sync <= !frame_sync;
  // Log each offer; ack mirrors flag so end mark frees it
  always @(posedge link_clk) begin
    if (frame_sync) begin
      if (!out_line_tx_flag_n && seen_hi) rxq.push_back(out_line_byte);
      seen_hi <= out_line_tx_flag_n;
      if (!ack_off) in_line_read_ack_n <= out_line_tx_flag_n;
    end
  end
  // Offer one byte, hold until acked, then end mark
  task automatic send(input logic [7:0] b);
    int n;
    @(posedge link_clk iff frame_sync);
    in_line_byte <= b;
    in_line_tx_flag_n <= 1'b0;
    n = 0;
    while (out_line_read_ack_n !== 1'b0 && n < 200) begin
      @(negedge link_clk);
      n++;
    end
    @(posedge link_clk iff frame_sync);
    in_line_tx_flag_n <= 1'b1;
    in_line_byte <= 8'hFF; // Released line floats up
    repeat (12) @(posedge link_clk);
  endtask
endmodule

// File: tb/mcq_sq_handler_tb.sv
// Testbench for the S/Q monitor handler.
// Assumes the checker and controller model are compiled first.
`timescale 1ns/10ps
module mcq_sq_handler_tb;
  logic ref_clk = 0, link_clk = 0, rst_n = 0, mf_strobe = 0, ack_off = 0;
  logic lt_mode = 0, multiframe_disable_bit = 0, timeout_disable_bit = 0;
  logic [3:0] line_rx_s1 = 4'h0, line_rx_s2 = 4'h0, line_rx_q = 4'h0;
  logic [3:0] line_tx_s1, line_tx_s2, line_tx_q;
  logic frame_sync, in_line_tx_flag_n, in_line_read_ack_n;
  logic out_line_tx_flag_n, out_line_read_ack_n;
  logic [7:0] in_line_byte, out_line_byte;
  int err_count = 0, checks = 0;
  always #5 ref_clk = !ref_clk;
  initial #37 forever #80 link_clk = !link_clk; // Phase unrelated to core
  mcq_sq_handler mcq_sq_handler_i (.ref_clk, .rst_n, .lt_mode, .multiframe_disable_bit,
    .timeout_disable_bit, .mf_strobe, .line_rx_s1, .line_rx_s2, .line_rx_q, .line_tx_s1,
    .line_tx_s2, .line_tx_q, .link_clk, .frame_sync, .in_line_byte, .in_line_tx_flag_n,
    .in_line_read_ack_n, .out_line_byte, .out_line_tx_flag_n, .out_line_read_ack_n);
  mcq_ctrl_model mcq_ctrl_model_i (.link_clk, .frame_sync, .in_line_byte, .in_line_tx_flag_n,
    .in_line_read_ack_n, .out_line_byte, .out_line_tx_flag_n, .out_line_read_ack_n, .ack_off);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic links(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // One multiframe pulse with the given line nibbles
  task automatic strobe(input logic [3:0] s1, input logic [3:0] s2, input logic [3:0] q);
    @(posedge ref_clk);
    line_rx_s1 <= s1;
    line_rx_s2 <= s2;
    line_rx_q <= q;
    mf_strobe <= 1'b1;
    @(posedge ref_clk) mf_strobe <= 1'b0;
    links(60);
  endtask
  // Host writes reach the holding registers per direction
  task automatic t_write();
    mcq_ctrl_model_i.send(8'h1A);
    check({4'h0, line_tx_q}, 8'h0A, "q write");
    mcq_ctrl_model_i.send(8'h10);
    check({4'h0, line_tx_q}, 8'h00, "q zero");
    @(posedge ref_clk) lt_mode <= 1'b1;
    mcq_ctrl_model_i.send(8'h15);
    check({4'h0, line_tx_s1}, 8'h05, "s1 write");
    mcq_ctrl_model_i.send(8'h2F);
    check({4'h0, line_tx_s2}, 8'h0F, "s2 write");
    $display("test write done");
  endtask
  // Line nibbles come out as messages per direction
  task automatic t_read();
    mcq_ctrl_model_i.rxq.delete();
    strobe(4'h6, 4'h9, 4'h6);
    check(8'(mcq_ctrl_model_i.rxq.size()), 8'h01, "lt count");
    check(mcq_ctrl_model_i.rxq[0], 8'h16, "q read");
    @(posedge ref_clk) lt_mode <= 1'b0;
    mcq_ctrl_model_i.rxq.delete();
    strobe(4'h3, 4'h9, 4'h5);
    mcq_ctrl_model_i.rxq.sort();
    check(mcq_ctrl_model_i.rxq[0], 8'h13, "s1 read");
    check(mcq_ctrl_model_i.rxq[1], 8'h29, "s2 read");
    $display("test read done");
  endtask
  // No messages go out on a multiframe strobe with multiframing off
  task automatic t_mfd();
    @(posedge ref_clk) multiframe_disable_bit <= 1'b1;
    mcq_ctrl_model_i.rxq.delete();
    links(8);
    strobe(4'h4, 4'h4, 4'h4);
    check(8'(mcq_ctrl_model_i.rxq.size()), 8'h00, "mfd quiet");
    @(posedge ref_clk) multiframe_disable_bit <= 1'b0;
    $display("test mfd done");
  endtask
  // Stalled ack: end mark then resend; none when disabled
  task automatic t_timeout();
    @(posedge ref_clk) lt_mode <= 1'b1;
    ack_off <= 1'b1;
    mcq_ctrl_model_i.rxq.delete();
    strobe(4'h0, 4'h0, 4'h7);
    links(200);
    check({7'h0, mcq_ctrl_model_i.rxq.size() > 1}, 8'h01, "resend");
    check(mcq_ctrl_model_i.rxq[1], 8'h17, "resent byte");
    wait (out_line_tx_flag_n === 1'b0); // Set early in an offer, far from its timeout
    @(posedge ref_clk) timeout_disable_bit <= 1'b1;
    links(20);
    mcq_ctrl_model_i.rxq.delete();
    links(240);
    check(8'(mcq_ctrl_model_i.rxq.size()), 8'h00, "no timeout");
    @(posedge ref_clk) ack_off <= 1'b0;
    links(40);
    @(posedge ref_clk) timeout_disable_bit <= 1'b0;
    $display("test timeout done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    links(8);
    t_write();
    t_read();
    t_mfd();
    t_timeout();
    summarize();
  end
endmodule
